/* File: rtl/rx_overhead_capture_defs.svh */
// register offsets, field positions and reset values of the receive overhead capture block
`ifndef RX_OVERHEAD_CAPTURE_DEFS_SVH
`define RX_OVERHEAD_CAPTURE_DEFS_SVH

// ==========================================================================
// address layout
`define ROC_PORT_STRIDE 12'h200
`define ROC_PORT_MSB 10
`define ROC_PORT_LSB 9
`define ROC_OFF_MSB 8
`define ROC_ADDR_W 11

// ==========================================================================
// offsets inside one port copy
`define ROC_OFF_LINK_BYTE 9'h062
`define ROC_OFF_CODE_WORD 9'h063
`define ROC_OFF_SLC_A 9'h064
`define ROC_OFF_SLC_B 9'h065
`define ROC_OFF_SLC_C 9'h066
`define ROC_OFF_ALIGN 9'h064
`define ROC_OFF_NONALIGN 9'h065
`define ROC_OFF_SI_EVEN 9'h066
`define ROC_OFF_SI_ODD 9'h067
`define ROC_OFF_ALARM 9'h068
`define ROC_OFF_NAT4 9'h069
`define ROC_OFF_NAT5 9'h06A
`define ROC_OFF_NAT6 9'h06B
`define ROC_OFF_NAT7 9'h06C
`define ROC_OFF_CTRL 9'h07F

// ==========================================================================
// control fields and reset values
`define ROC_CTRL_LINE_STD 0
`define ROC_CTRL_D4 1
`define ROC_CTRL_W 2
`define ROC_RESET_BYTE 8'h00
`define ROC_LAST_FRAME 4'hF

// ==========================================================================
// time-slot-0 field positions in the non-align frame
`define ROC_TS0_SI 7
`define ROC_TS0_ALARM 5
`define ROC_TS0_NAT4 4
`define ROC_TS0_NAT5 3
`define ROC_TS0_NAT6 2
`define ROC_TS0_NAT7 1

`endif

/* File: rtl/rx_overhead_capture_pkg.sv */
// types of the receive overhead capture block
package rx_overhead_capture_pkg;

  // ========================================================================
  // one port copy of captures, shadows and control
  typedef struct packed {
    logic [1:0] ctrl;
    logic [5:0] rxCodeWord;
    logic [7:0] rxLinkByte;
    logic [7:0] linkShift;
    logic [2:0] linkCount;
    logic [23:0] slcShift;
    logic [23:0] slcLink;
    logic [7:0] alignCapture;
    logic [7:0] nonalignCapture;
    logic [7:0] siEvenShadow;
    logic [7:0] siOddShadow;
    logic [7:0] alarmShadow;
    logic [7:0] nat4Shadow;
    logic [7:0] nat5Shadow;
    logic [7:0] nat6Shadow;
    logic [7:0] nat7Shadow;
    logic [7:0] siEven;
    logic [7:0] siOdd;
    logic [7:0] alarmBits;
    logic [7:0] nat4;
    logic [7:0] nat5;
    logic [7:0] nat6;
    logic [7:0] nat7;
  } port_t;

  typedef struct packed {
    port_t [3:0] p;
    logic [7:0] rdData;
  } state_t;

endpackage

/* File: rtl/rx_overhead_capture.sv */
// receive overhead capture for four LINE_STANDARD_SELECT ports with a plain register port
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rx_overhead_capture_defs.svh"

// Operation
// - code word register keeps the last valid code until a new one
// - link byte shows facility link or Fs bits, earliest bit in LSB
// - in D4 link byte updates on multiframe edges, six Fs bits in 5:0
// - offsets 064h..066h show SLC fields in T1, time-slot-0 captures in E1
// - align capture holds Si in bit 7, alignment signal in 6..0
// - non-align capture holds Si, fixed 1, alarm, then Sa4..Sa8
// - even-frame Si bits gathered, frame 14 in bit 7 to frame 0
// - odd-frame Si bits gathered, frame 15 in bit 7 to frame 1
// - alarm bits of odd frames gathered, frame 15 in bit 7
// - Sa4 bits of odd frames gathered, frame 15 in bit 7
// - Sa5 bits of odd frames gathered in their own byte
// - Sa6 bits of odd frames gathered in their own byte
// - four port copies, each at base plus 200h times port index
// - every capture register reads zero after reset until data arrives
// - code word is six bits in 5..0, bits 7 and 6 read zero
// - Sa7 bits of odd frames gathered at 06Ch, frame 15 in bit 7
module rx_overhead_capture
#(
  parameter int NUM_PORTS = 4
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`ROC_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic [3:0] codeWordValid,
  input wire logic [3:0][5:0] codeWord,
  input wire logic [3:0] linkBitValid,
  input wire logic [3:0] linkBit,
  input wire logic [3:0] t1MfBoundary,
  input wire logic [3:0] slcLatch,
  input wire logic [3:0] ts0Valid,
  input wire logic [3:0][7:0] ts0Byte,
  input wire logic [3:0][3:0] e1Frame,
  input wire logic [3:0] e1Sync
);
  import rx_overhead_capture_pkg::*;

  // ========================================================================
  // elaboration check
  if (NUM_PORTS < 1 || NUM_PORTS > 4)
  begin : g_bad_ports
    $error("NUM_PORTS must lie between 1 and 4");
  end

  // ========================================================================
  // address decode
  function automatic logic [1:0] portOf(input logic [`ROC_ADDR_W-1:0] a);
    portOf = a[`ROC_PORT_MSB:`ROC_PORT_LSB];
  endfunction

  function automatic logic [8:0] offsetOf(input logic [`ROC_ADDR_W-1:0] a);
    offsetOf = a[`ROC_OFF_MSB:0];
  endfunction

  // the same offsets answer differently with the line standard
  function automatic logic [7:0] readByte(input port_t q, input logic [8:0] off);
    logic e1;
    e1 = q.ctrl[`ROC_CTRL_LINE_STD];
    readByte = `ROC_RESET_BYTE;
    case (off)
      `ROC_OFF_LINK_BYTE: readByte = e1 ? `ROC_RESET_BYTE : q.rxLinkByte;
      `ROC_OFF_CODE_WORD: readByte = e1 ? `ROC_RESET_BYTE : {2'b00, q.rxCodeWord};
      `ROC_OFF_SLC_A: readByte = e1 ? q.alignCapture : q.slcLink[7:0];
      `ROC_OFF_SLC_B: readByte = e1 ? q.nonalignCapture : q.slcLink[15:8];
      `ROC_OFF_SLC_C: readByte = e1 ? q.siEven : q.slcLink[23:16];
      `ROC_OFF_SI_ODD: readByte = q.siOdd;
      `ROC_OFF_ALARM: readByte = q.alarmBits;
      `ROC_OFF_NAT4: readByte = q.nat4;
      `ROC_OFF_NAT5: readByte = q.nat5;
      `ROC_OFF_NAT6: readByte = q.nat6;
      `ROC_OFF_NAT7: readByte = q.nat7;
      `ROC_OFF_CTRL: readByte = {6'h00, q.ctrl};
      default: readByte = `ROC_RESET_BYTE;
    endcase
  endfunction

  // ========================================================================
  // state
  state_t st_r;
  state_t st_nxt;

  always_comb
  begin
    logic [3:0] fr;
    logic [2:0] idx;
    logic [1:0] rp;
    fr = 4'h0;
    idx = 3'h0;
    rp = portOf(regAddr);
    st_nxt = st_r;
    st_nxt.rdData = `ROC_RESET_BYTE;
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      if (!st_r.p[i].ctrl[`ROC_CTRL_LINE_STD])
      begin
        // T1: only a validated code replaces the stored one
        if (codeWordValid[i])
        begin
          st_nxt.p[i].rxCodeWord = codeWord[i];
        end
        if (linkBitValid[i])
        begin
          // shift right so the earliest bit lands lowest
          st_nxt.p[i].linkShift = {linkBit[i], st_r.p[i].linkShift[7:1]};
          st_nxt.p[i].linkCount = st_r.p[i].linkCount + 3'd1;
          st_nxt.p[i].slcShift = {linkBit[i], st_r.p[i].slcShift[23:1]};
          if (!st_r.p[i].ctrl[`ROC_CTRL_D4] && st_r.p[i].linkCount == 3'd7)
          begin
            st_nxt.p[i].rxLinkByte = st_nxt.p[i].linkShift;
          end
        end
        if (t1MfBoundary[i] && st_r.p[i].ctrl[`ROC_CTRL_D4])
        begin
          // six Fs bits sit in the top of the shifter after a multiframe
          st_nxt.p[i].rxLinkByte = {2'b00, st_nxt.p[i].linkShift[7:2]};
          st_nxt.p[i].linkCount = 3'd0;
        end
        if (slcLatch[i])
        begin
          // first received bit C1 ends in bit 0 of the first byte
          st_nxt.p[i].slcLink = st_nxt.p[i].slcShift;
        end
      end
      else if (ts0Valid[i])
      begin
        fr = e1Frame[i];
        idx = fr[3:1];
        if (!fr[0])
        begin
          st_nxt.p[i].alignCapture = ts0Byte[i];
          st_nxt.p[i].siEvenShadow[idx] = ts0Byte[i][`ROC_TS0_SI];
        end
        else
        begin
          st_nxt.p[i].nonalignCapture = ts0Byte[i];
          st_nxt.p[i].siOddShadow[idx] = ts0Byte[i][`ROC_TS0_SI];
          st_nxt.p[i].alarmShadow[idx] = ts0Byte[i][`ROC_TS0_ALARM];
          st_nxt.p[i].nat4Shadow[idx] = ts0Byte[i][`ROC_TS0_NAT4];
          st_nxt.p[i].nat5Shadow[idx] = ts0Byte[i][`ROC_TS0_NAT5];
          st_nxt.p[i].nat6Shadow[idx] = ts0Byte[i][`ROC_TS0_NAT6];
          st_nxt.p[i].nat7Shadow[idx] = ts0Byte[i][`ROC_TS0_NAT7];
        end
        // committing only at frame 15 keeps each byte from one multiframe
        if (fr == `ROC_LAST_FRAME && e1Sync[i])
        begin
          st_nxt.p[i].siEven = st_nxt.p[i].siEvenShadow;
          st_nxt.p[i].siOdd = st_nxt.p[i].siOddShadow;
          st_nxt.p[i].alarmBits = st_nxt.p[i].alarmShadow;
          st_nxt.p[i].nat4 = st_nxt.p[i].nat4Shadow;
          st_nxt.p[i].nat5 = st_nxt.p[i].nat5Shadow;
          st_nxt.p[i].nat6 = st_nxt.p[i].nat6Shadow;
          st_nxt.p[i].nat7 = st_nxt.p[i].nat7Shadow;
        end
      end
    end
    // register port: only the control byte is writable
    if (regWr && offsetOf(regAddr) == `ROC_OFF_CTRL && int'(rp) < NUM_PORTS)
    begin
      st_nxt.p[rp].ctrl = regWrData[`ROC_CTRL_W-1:0];
    end
    if (regRd && int'(rp) < NUM_PORTS)
    begin
      st_nxt.rdData = readByte(st_r.p[rp], offsetOf(regAddr));
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rdData;

  // ========================================================================
  // assertions, port 0 and port 1 stand for all copies
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  logic t1Mode0;
  logic d4Mode0;
  assign t1Mode0 = !st_r.p[0].ctrl[`ROC_CTRL_LINE_STD];
  assign d4Mode0 = st_r.p[0].ctrl[`ROC_CTRL_D4];

  sequence seqCommit0;
    !t1Mode0 && ts0Valid[0] && e1Frame[0] == 4'hF && e1Sync[0];
  endsequence

  sequence seqReadNonalign1;
    regRd && !regWr && regAddr == 11'h265 && st_r.p[1].ctrl[0];
  endsequence

  AST_CODE_HOLD: assert property (!codeWordValid[0] |=> $stable(st_r.p[0].rxCodeWord))
    else $error("code word changed without a valid code");

  AST_CODE_LOAD: assert property (t1Mode0 && codeWordValid[0]
    |=> st_r.p[0].rxCodeWord == $past(codeWord[0]))
    else $error("valid code word not stored");

  AST_D4_HOLD: assert property (t1Mode0 && d4Mode0 && !t1MfBoundary[0] && !regWr
    |=> $stable(st_r.p[0].rxLinkByte))
    else $error("D4 link byte changed off a multiframe edge");

  AST_D4_TOP_ZERO: assert property (t1Mode0 && d4Mode0 && t1MfBoundary[0]
    |=> st_r.p[0].rxLinkByte[7:6] == 2'b00)
    else $error("D4 link byte top bits not zero");

  AST_RESET_ZERO: assert property (@(posedge sys_clk) disable iff (1'b0)
    rst |=> st_r.p[0].nat7 == 8'h00 && st_r.p[0].slcLink == 24'h000000
    && regRdData == 8'h00)
    else $error("capture not cleared by reset");

  AST_SI_EVEN_WAIT: assert property (!(ts0Valid[0] && e1Frame[0] == 4'hF)
    |=> $stable(st_r.p[0].siEven))
    else $error("even Si byte changed away from frame 15");

  AST_ALIGN_CAPTURE: assert property (!t1Mode0 && ts0Valid[0] && !e1Frame[0][0]
    |=> st_r.p[0].alignCapture == $past(ts0Byte[0]))
    else $error("align frame byte not captured");

  AST_NONALIGN_READ: assert property (seqReadNonalign1
    ##1 1'b1 |-> regRdData == $past(st_r.p[1].nonalignCapture))
    else $error("non-align capture of port 1 read wrong");

  AST_SA7_F15: assert property (seqCommit0
    |=> st_r.p[0].nat7[7] == $past(ts0Byte[0][1]))
    else $error("Sa7 of frame 15 not committed to bit 7");

  AST_ALARM_F15: assert property (seqCommit0
    |=> st_r.p[0].alarmBits[7] == $past(ts0Byte[0][5])
    && st_r.p[0].alarmBits[6:0] == $past(st_r.p[0].alarmShadow[6:0]))
    else $error("alarm byte commit wrong");

  AST_RD_ONE_CYCLE: assert property (!regRd |=> regRdData == 8'h00)
    else $error("read data stood outside the read answer cycle");

  // ========================================================================
  // line standard and register port, ports 0, 1 and 3 stand for all copies
  sequence seqCtrlWrite0;
    regWr && regAddr == {2'b00, `ROC_OFF_CTRL};
  endsequence

  sequence seqReadCode;
    regRd && regAddr[`ROC_OFF_MSB:0] == `ROC_OFF_CODE_WORD;
  endsequence

  sequence seqReadLink0E1;
    regRd && regAddr == {2'b00, `ROC_OFF_LINK_BYTE} && !t1Mode0;
  endsequence

  sequence seqReadNat7Port3;
    regRd && regAddr == {2'b11, `ROC_OFF_NAT7};
  endsequence

  AST_CTRL_WRITE: assert property (seqCtrlWrite0
    |=> st_r.p[0].ctrl == $past(regWrData[1:0]))
    else $error("control byte of port 0 not written");

  AST_CTRL_KEEP: assert property (!(regWr && regAddr == {2'b00, `ROC_OFF_CTRL})
    |=> $stable(st_r.p[0].ctrl))
    else $error("control byte of port 0 changed without a write");

  AST_CODE_TOP_ZERO: assert property (seqReadCode |=> regRdData[7:6] == 2'b00)
    else $error("unused code word bits read nonzero");

  AST_E1_LINK_READ: assert property (seqReadLink0E1 |=> regRdData == 8'h00)
    else $error("link byte offset answered in E1 mode");

  AST_PORT3_READ: assert property (seqReadNat7Port3
    |=> regRdData == $past(st_r.p[3].nat7))
    else $error("Sa7 byte of port 3 read wrong");

  AST_CTRL_READ: assert property (regRd && regAddr == {2'b01, `ROC_OFF_CTRL}
    |=> regRdData == {6'h00, $past(st_r.p[1].ctrl)})
    else $error("control byte of port 1 read wrong");

  // ========================================================================
  // T1 link and code word
  AST_E1_T1_IGNORED: assert property (!t1Mode0
    |=> $stable(st_r.p[0].rxCodeWord) && $stable(st_r.p[0].rxLinkByte)
    && $stable(st_r.p[0].slcLink))
    else $error("T1 capture moved while port 0 runs E1");

  AST_ESF_COMMIT: assert property (t1Mode0 && !d4Mode0 && linkBitValid[0]
    && st_r.p[0].linkCount == 3'd7
    |=> st_r.p[0].rxLinkByte[7] == $past(linkBit[0])
    && st_r.p[0].rxLinkByte[6:0] == $past(st_r.p[0].linkShift[7:1]))
    else $error("ESF link byte not committed after eight bits");

  AST_ESF_HOLD: assert property (t1Mode0 && !d4Mode0
    && !(linkBitValid[0] && st_r.p[0].linkCount == 3'd7)
    |=> $stable(st_r.p[0].rxLinkByte))
    else $error("ESF link byte changed between byte edges");

  AST_D4_FS_BITS: assert property (t1Mode0 && d4Mode0 && t1MfBoundary[0]
    && !linkBitValid[0]
    |=> st_r.p[0].rxLinkByte[5:0] == $past(st_r.p[0].linkShift[7:2]))
    else $error("D4 Fs bits not placed in bits 5 to 0");

  AST_D4_COUNT_CLEAR: assert property (t1Mode0 && d4Mode0 && t1MfBoundary[0]
    && !linkBitValid[0] |=> st_r.p[0].linkCount == 3'd0)
    else $error("link bit counter not cleared on a D4 multiframe edge");

  AST_SLC_LATCH: assert property (t1Mode0 && slcLatch[0] && !linkBitValid[0]
    |=> st_r.p[0].slcLink == $past(st_r.p[0].slcShift))
    else $error("SLC bytes not latched from the link shifter");

  AST_SLC_HOLD: assert property (!slcLatch[0] |=> $stable(st_r.p[0].slcLink))
    else $error("SLC bytes changed without a latch");

  // ========================================================================
  // E1 time slot 0 and multiframe commits
  AST_T1_TS0_IGNORED: assert property (t1Mode0
    |=> $stable(st_r.p[0].alignCapture) && $stable(st_r.p[0].nonalignCapture)
    && $stable(st_r.p[0].siOdd))
    else $error("E1 capture moved while port 0 runs T1");

  AST_TS0_HOLD: assert property (!ts0Valid[0]
    |=> $stable(st_r.p[0].alignCapture) && $stable(st_r.p[0].nonalignCapture))
    else $error("time slot 0 capture changed without a valid byte");

  AST_NONALIGN_CAPTURE: assert property (!t1Mode0 && ts0Valid[0] && e1Frame[0][0]
    |=> st_r.p[0].nonalignCapture == $past(ts0Byte[0]))
    else $error("non-align frame byte not captured");

  AST_SI_EVEN_COMMIT: assert property (seqCommit0
    |=> st_r.p[0].siEven == $past(st_r.p[0].siEvenShadow))
    else $error("even Si byte commit wrong");

  AST_SI_ODD_F15: assert property (seqCommit0
    |=> st_r.p[0].siOdd[7] == $past(ts0Byte[0][`ROC_TS0_SI]))
    else $error("Si of frame 15 not committed to bit 7");

  AST_NAT4_F15: assert property (seqCommit0
    |=> st_r.p[0].nat4[7] == $past(ts0Byte[0][`ROC_TS0_NAT4]))
    else $error("Sa4 of frame 15 not committed to bit 7");

  AST_NAT5_F15: assert property (seqCommit0
    |=> st_r.p[0].nat5[7] == $past(ts0Byte[0][`ROC_TS0_NAT5]))
    else $error("Sa5 of frame 15 not committed to bit 7");

  AST_NAT6_F15: assert property (seqCommit0
    |=> st_r.p[0].nat6[7] == $past(ts0Byte[0][`ROC_TS0_NAT6]))
    else $error("Sa6 of frame 15 not committed to bit 7");

  AST_NAT7_WAIT: assert property (!(ts0Valid[0] && e1Frame[0] == `ROC_LAST_FRAME)
    |=> $stable(st_r.p[0].nat7))
    else $error("Sa7 byte changed away from frame 15");

  AST_NO_SYNC_HOLD: assert property (st_r.p[1].ctrl[`ROC_CTRL_LINE_STD] && ts0Valid[1]
    && !e1Sync[1] |=> $stable(st_r.p[1].siOdd) && $stable(st_r.p[1].nat4))
    else $error("multiframe byte committed without sync");

endmodule
`default_nettype wire

/* File: tb/rx_overhead_far_end.sv */
// far-end framer model that hands received overhead bits to the capture block
`timescale 1ns/1ps
`default_nettype none
module rx_overhead_far_end
(
  input wire logic sys_clk,
  output logic [3:0] codeWordValid,
  output logic [3:0][5:0] codeWord,
  output logic [3:0] linkBitValid,
  output logic [3:0] linkBit,
  output logic [3:0] t1MfBoundary,
  output logic [3:0] slcLatch,
  output logic [3:0] ts0Valid,
  output logic [3:0][7:0] ts0Byte,
  output logic [3:0][3:0] e1Frame,
  output logic [3:0] e1Sync
);
  // ====================
  // idle levels
  initial
  begin
    {codeWordValid, linkBitValid, t1MfBoundary, slcLatch, ts0Valid, e1Sync} = '0;
    {codeWord, linkBit, ts0Byte, e1Frame} = '0;
  end
  // ====================
  // one pulse per call; data flips to its inverse after the pulse,
  // so a capture that samples outside its pulse shows up
  task automatic code(input int p, input logic [5:0] c);
    @(posedge sys_clk);
    codeWord[p] <= c;
    codeWordValid[p] <= 1'b1;
    @(posedge sys_clk);
    codeWordValid[p] <= 1'b0;
    codeWord[p] <= ~c;
  endtask
  task automatic link(input int p, input logic b);
    @(posedge sys_clk);
    linkBit[p] <= b;
    linkBitValid[p] <= 1'b1;
    @(posedge sys_clk);
    linkBitValid[p] <= 1'b0;
    linkBit[p] <= ~b;
  endtask
  task automatic mark(input int p, input logic slc);
    @(posedge sys_clk);
    if (slc)
      slcLatch[p] <= 1'b1;
    else
      t1MfBoundary[p] <= 1'b1;
    @(posedge sys_clk);
    slcLatch[p] <= 1'b0;
    t1MfBoundary[p] <= 1'b0;
  endtask
  task automatic ts0(input int p, input int f, input logic [7:0] b, input logic s);
    @(posedge sys_clk);
    ts0Valid[p] <= 1'b1;
    ts0Byte[p] <= b;
    e1Frame[p] <= 4'(f);
    e1Sync[p] <= s;
    @(posedge sys_clk);
    ts0Valid[p] <= 1'b0;
    ts0Byte[p] <= ~b;
    e1Frame[p] <= ~4'(f);
  endtask
endmodule
`default_nettype wire

/* File: tb/rx_overhead_capture_bench.sv */
// self-checking bench of the receive overhead capture block
`timescale 1ns/1ps
`default_nettype none
`include "rx_overhead_capture_defs.svh"
`define CHK(a, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      numErrors++; \
      $display("CHECK FAILED reg %h expected %h seen %h", a, e, g); \
    end \
  end
module rx_overhead_capture_bench;
  import rx_overhead_capture_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [`ROC_ADDR_W-1:0] regAddr = '0;
  logic [7:0] regWrData = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic [3:0] codeWordValid, linkBitValid, linkBit, t1MfBoundary, slcLatch, ts0Valid, e1Sync;
  logic [3:0][5:0] codeWord;
  logic [3:0][7:0] ts0Byte;
  logic [3:0][3:0] e1Frame;
  int numErrors = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] expv [7];
  logic [23:0] slcBits = 24'h6BD24E;
  logic [15:0] pat [6] = '{16'h9C35, 16'h6A1E, 16'hB2C7, 16'h4E8D, 16'hD153, 16'h27F0};
  // ====================
  // design and far end
  rx_overhead_capture #(.NUM_PORTS(4)) i_dut
  (
    .sys_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .codeWordValid, .codeWord, .linkBitValid, .linkBit, .t1MfBoundary,
    .slcLatch, .ts0Valid, .ts0Byte, .e1Frame, .e1Sync
  );
  rx_overhead_far_end i_far
  (
    .sys_clk, .codeWordValid, .codeWord, .linkBitValid, .linkBit,
    .t1MfBoundary, .slcLatch, .ts0Valid, .ts0Byte, .e1Frame, .e1Sync
  );
  // ====================
  // register port
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic chk(input logic [10:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    `CHK(a, e, regRdData)
  endtask
  // time slot 0 of frame f: alignment word in even frames
  function automatic logic [7:0] fb(input int f);
    if (f % 2 == 0)
      return {pat[0][f], 7'h1B};
    return {pat[0][f], 1'b1, pat[1][f], pat[2][f], pat[3][f], pat[4][f], pat[5][f], 1'b0};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ====================
  // clock and hang guard
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      numErrors++;
      close_out();
    end
  end
  // ====================
  // tests
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 'h62; a <= 'h70; a++)
    begin
      chk(11'(a), 8'h00);
      chk(11'h600 + 11'(a), 8'h00);
    end
    $display("test reset done");
    i_far.code(0, 6'h2D);
    chk(11'h063, 8'h2D);
    i_far.code(0, 6'h12);
    chk(11'h063, 8'h12);
    for (int i = 0; i < 24; i++)
      i_far.link(0, slcBits[i]);
    chk(11'h062, slcBits[23:16]);
    i_far.mark(0, 1'b1);
    for (int i = 0; i < 3; i++)
      chk(11'h064 + 11'(i), slcBits[8*i +: 8]);
    $display("test t1 link done");
    wr(11'h07F, 8'h02);
    for (int i = 0; i < 6; i++)
      i_far.link(0, 1'(6'h29 >> i));
    chk(11'h062, slcBits[23:16]);
    i_far.mark(0, 1'b0);
    chk(11'h062, 8'h29);
    $display("test d4 done");
    wr(11'h27F, 8'h01);
    chk(11'h27F, 8'h01);
    i_far.ts0(1, 15, 8'hFF, 1'b0);
    chk(11'h267, 8'h00);
    for (int f = 0; f < 16; f++)
      i_far.ts0(1, f, fb(f), 1'b1);
    chk(11'h264, fb(14));
    chk(11'h265, fb(15));
    for (int k = 0; k < 8; k++)
      for (int r = 0; r < 7; r++)
        expv[r][k] = (r == 0) ? pat[0][2*k] : pat[r-1][2*k+1];
    for (int r = 0; r < 7; r++)
      chk(11'h266 + 11'(r), expv[r]);
    chk(11'h064, slcBits[7:0]);
    $display("test e1 done");
    wr(11'h07F, 8'h01);
    i_far.code(0, 6'h3F);
    i_far.link(0, 1'b1);
    wr(11'h063, 8'h3F);
    chk(11'h062, 8'h00);
    chk(11'h063, 8'h00);
    for (int f = 0; f < 16; f++)
      i_far.ts0(0, f, ~fb(f), 1'b1);
    chk(11'h064, ~fb(14));
    chk(11'h068, ~expv[2]);
    chk(11'h06C, ~expv[6]);
    wr(11'h07F, 8'h00);
    chk(11'h062, 8'h29);
    chk(11'h063, 8'h12);
    $display("test e1 port 0 done");
    close_out();
  end
endmodule
`default_nettype wire
